/* design/fsc_pkg.sv */
package fsc_pkg;
	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam logic [15:0] INFO_BASE     = 16'h1000;
	localparam logic [15:0] INFO_TOP      = 16'h10FF;
	localparam logic [15:0] MAIN_BASE     = 16'hF800;
	localparam logic [15:0] CAL_BC1_ADDR  = 16'h10FF;
	localparam logic [15:0] CAL_DCO_ADDR  = 16'h10FE;

	// ----------------------------------------------------------------
	// array layout (byte index: info first, then main)
	// ----------------------------------------------------------------
	localparam int          MEM_BYTES     = 2304;
	localparam logic [11:0] MAIN_IDX      = 12'h100;
	localparam logic [11:0] MEM_LAST_IDX  = 12'h8FF;
	localparam logic [11:0] MAIN_SEG_SPAN = 12'h1FF;
	localparam logic [11:0] INFO_SEG_SPAN = 12'h03F;
	localparam logic [11:0] SEGA_FIRST    = 12'h0C0;
	localparam logic [11:0] SEGA_LAST     = 12'h0FF;
	localparam logic [7:0]  ERASED_BYTE   = 8'hFF;

	// ----------------------------------------------------------------
	// commands and states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_READ       = 3'h0,
		CMD_PROG_BYTE  = 3'h1,
		CMD_PROG_WORD  = 3'h2,
		CMD_ERASE_SEG  = 3'h3,
		CMD_ERASE_MASS = 3'h4,
		CMD_ERASE_ALL  = 3'h5
	} fsc_cmd_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_ERASE = 2'h1,
		ST_DONE  = 2'h3
	} fsc_state_e;

	typedef struct packed {
		fsc_state_e  st;
		logic [11:0] ptr;
		logic [11:0] last;
		logic        owner_dbg;
		logic        cpu_ack;
		logic        dbg_ack;
		logic        err;
		logic [15:0] rdata;
		logic        busy;
		logic        locked;
	} fsc_state_s;
endpackage : fsc_pkg

/* design/fsc_flash_segment_control.sv */
`timescale 1ns/1ns
module fsc_flash_segment_control (
	// clock and reset
	input  wire logic            i_clk,
	input  wire logic            i_rst_b,
	input  wire logic            i_ce,
	// cpu port, request held until ack
	input  wire logic            i_cpu_req,
	input  wire fsc_pkg::fsc_cmd_e i_cpu_cmd,
	input  wire logic [15:0]     i_cpu_addr,
	input  wire logic [15:0]     i_cpu_wdata,
	output logic                 o_cpu_ack,
	// debug port, request held until ack
	input  wire logic            i_dbg_req,
	input  wire fsc_pkg::fsc_cmd_e i_dbg_cmd,
	input  wire logic [15:0]     i_dbg_addr,
	input  wire logic [15:0]     i_dbg_wdata,
	output logic                 o_dbg_ack,
	// shared answer
	output logic [15:0]          o_rdata,
	output logic                 o_err,
	output logic                 o_busy,
	// segment a protection
	input  wire logic            i_sega_unlock,
	input  wire logic            i_sega_lock,
	output logic                 o_sega_locked
);
	import fsc_pkg::*;

	// ----------------------------------------------------------------
	// storage and request select
	// ----------------------------------------------------------------
	logic [7:0]  mem [0:MEM_BYTES-1];
	fsc_state_s  s_q;
	fsc_state_s  s_d;
	logic        mem_we0;
	logic        mem_we1;
	logic [11:0] mem_idx0;
	logic [7:0]  mem_wd0;
	logic [7:0]  mem_wd1;
	logic        sel_req;
	logic        sel_dbg;
	fsc_cmd_e    sel_cmd;
	logic [15:0] sel_addr;
	logic [15:0] sel_wdata;
	logic        in_info;
	logic        in_main;
	logic [11:0] req_idx;
	logic [11:0] word_idx;
	logic [11:0] seg_first;
	logic [11:0] seg_last;
	logic        hits_a;

	assign sel_dbg   = i_dbg_req;
	assign sel_req   = i_dbg_req | i_cpu_req;
	assign sel_cmd   = sel_dbg ? i_dbg_cmd : i_cpu_cmd;
	assign sel_addr  = sel_dbg ? i_dbg_addr : i_cpu_addr;
	assign sel_wdata = sel_dbg ? i_dbg_wdata : i_cpu_wdata;

	assign in_info   = (sel_addr >= INFO_BASE) && (sel_addr <= INFO_TOP);
	assign in_main   = (sel_addr >= MAIN_BASE);
	assign req_idx   = in_info ? {4'h0, sel_addr[7:0]} : MAIN_IDX + {1'b0, sel_addr[10:0]};
	assign word_idx  = {req_idx[11:1], 1'b0};
	// main segments are 512 bytes, info segments 64 bytes
	assign seg_first = in_info ? {4'h0, sel_addr[7:6], 6'h00}
	                           : MAIN_IDX + {1'b0, sel_addr[10:9], 9'h000};
	assign seg_last  = seg_first + (in_info ? INFO_SEG_SPAN : MAIN_SEG_SPAN);
	assign hits_a    = in_info && (req_idx >= SEGA_FIRST);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		s_d         = s_q;
		s_d.cpu_ack = 1'b0;
		s_d.dbg_ack = 1'b0;
		mem_we0     = 1'b0;
		mem_we1     = 1'b0;
		mem_idx0    = req_idx;
		mem_wd0     = ERASED_BYTE;
		mem_wd1     = ERASED_BYTE;
		if (i_sega_unlock) begin
			s_d.locked = 1'b0;
		end else if (i_sega_lock) begin
			s_d.locked = 1'b1;
		end
		case (s_q.st)
			ST_IDLE: begin
				if (sel_req) begin
					s_d.owner_dbg = sel_dbg;
					s_d.err       = 1'b0;
					s_d.busy      = 1'b1;
					s_d.st        = ST_DONE;
					case (sel_cmd)
						CMD_READ: begin
							if (in_info || in_main) begin
								s_d.rdata = {mem[word_idx + 12'h001], mem[word_idx]};
								if (sel_addr[0]) begin
									s_d.rdata = {8'h00, mem[req_idx]};
								end
							end else begin
								s_d.err = 1'b1;
							end
						end
						CMD_PROG_BYTE, CMD_PROG_WORD: begin
							if (!(in_info || in_main) || (hits_a && s_q.locked)) begin
								s_d.err = 1'b1;
							end else if (sel_cmd == CMD_PROG_BYTE) begin
								// flash programming can only clear bits
								mem_we0 = 1'b1;
								mem_wd0 = mem[req_idx] & sel_wdata[7:0];
							end else begin
								mem_we0  = 1'b1;
								mem_we1  = 1'b1;
								mem_idx0 = word_idx;
								mem_wd0  = mem[word_idx] & sel_wdata[7:0];
								mem_wd1  = mem[word_idx + 12'h001] & sel_wdata[15:8];
							end
						end
						CMD_ERASE_SEG: begin
							if (!(in_info || in_main) || (hits_a && s_q.locked)) begin
								s_d.err = 1'b1;
							end else begin
								s_d.ptr  = seg_first;
								s_d.last = seg_last;
								s_d.st   = ST_ERASE;
							end
						end
						CMD_ERASE_MASS: begin
							s_d.ptr  = MAIN_IDX;
							s_d.last = MEM_LAST_IDX;
							s_d.st   = ST_ERASE;
						end
						CMD_ERASE_ALL: begin
							s_d.ptr  = 12'h000;
							s_d.last = MEM_LAST_IDX;
							s_d.st   = ST_ERASE;
						end
						default: begin
							s_d.err = 1'b1;
						end
					endcase
					if (s_d.st == ST_DONE) begin
						s_d.cpu_ack = !sel_dbg;
						s_d.dbg_ack = sel_dbg;
					end
				end
			end
			ST_ERASE: begin
				// one byte per cycle keeps the write path the same as programming
				mem_idx0 = s_q.ptr;
				mem_we0  = !(s_q.locked && (s_q.ptr >= SEGA_FIRST) && (s_q.ptr <= SEGA_LAST));
				if (s_q.ptr == s_q.last) begin
					s_d.st      = ST_DONE;
					s_d.cpu_ack = !s_q.owner_dbg;
					s_d.dbg_ack = s_q.owner_dbg;
				end else begin
					s_d.ptr = s_q.ptr + 12'h001;
				end
			end
			ST_DONE: begin
				s_d.busy = 1'b0;
				s_d.st   = ST_IDLE;
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q        <= '0;
			s_q.st     <= ST_IDLE;
			s_q.locked <= 1'b1;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	// array holds its contents through reset, as flash does
	always_ff @(posedge i_clk) begin
		if (i_ce && mem_we0) begin
			mem[mem_idx0] <= mem_wd0;
		end
		if (i_ce && mem_we1) begin
			mem[mem_idx0 + 12'h001] <= mem_wd1;
		end
	end

	assign o_cpu_ack     = s_q.cpu_ack;
	assign o_dbg_ack     = s_q.dbg_ack;
	assign o_rdata       = s_q.rdata;
	assign o_err         = s_q.err;
	assign o_busy        = s_q.busy;
	assign o_sega_locked = s_q.locked;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence take_s;
		(s_q.st == ST_IDLE) && sel_req && i_ce;
	endsequence

	sequence take_cmd_s(fsc_cmd_e c);
		take_s and (sel_cmd == c) && (in_info || in_main) && !(hits_a && s_q.locked);
	endsequence

	dbg_first_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		take_s and i_dbg_req |=> s_q.owner_dbg && (s_q.st != ST_DONE || s_q.dbg_ack))
		else $error("debug port lost arbitration");
	prog_byte_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		take_cmd_s(CMD_PROG_BYTE) |=> mem[$past(req_idx)] == $past(mem_wd0) && o_err == 1'b0)
		else $error("byte program wrong");
	main_seg_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		take_cmd_s(CMD_ERASE_SEG) and in_main |=> (s_q.last - s_q.ptr == MAIN_SEG_SPAN)
		&& ((s_q.ptr - MAIN_IDX) & MAIN_SEG_SPAN) == 12'h000)
		else $error("main segment range wrong");
	info_seg_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		take_cmd_s(CMD_ERASE_SEG) and in_info |=> (s_q.last - s_q.ptr == INFO_SEG_SPAN)
		&& (s_q.ptr[5:0] == 6'h00))
		else $error("info segment range wrong");
	mass_range_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		take_s and (sel_cmd == CMD_ERASE_MASS) |=> s_q.ptr == MAIN_IDX && s_q.last == MEM_LAST_IDX)
		else $error("mass erase range wrong");
	all_range_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		take_s and (sel_cmd == CMD_ERASE_ALL) |=> s_q.ptr == 12'h000 && s_q.st == ST_ERASE)
		else $error("full erase range wrong");
	reset_lock_a: assert property (@(posedge i_clk)
		$rose(i_rst_b) |-> o_sega_locked)
		else $error("segment a not locked after reset");
	cal_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		take_s and (sel_cmd == CMD_READ) && (sel_addr == CAL_BC1_ADDR)
		|=> o_rdata[7:0] == $past(mem[SEGA_LAST]) && !o_err)
		else $error("calibration byte read wrong");
	sega_guard_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		s_q.locked && mem_we0 |-> (mem_idx0 < SEGA_FIRST) || (mem_idx0 > SEGA_LAST))
		else $error("locked segment a written");
endmodule : fsc_flash_segment_control

/* tb/fsc_bus_master.sv */
`timescale 1ns/1ns
// ------
// bus master model: holds a request until it samples ack
// ------
module fsc_bus_master (
	// clock
	input  wire logic         i_clk,
	// answer
	input  wire logic         i_ack,
	// request
	output logic              o_req,
	output fsc_pkg::fsc_cmd_e o_cmd,
	output logic [15:0]       o_addr,
	output logic [15:0]       o_wdata
);
	import fsc_pkg::*;
	logic tmo = 1'h0;
	initial begin
		o_req = 1'h0;
		o_cmd = CMD_READ;
		o_addr = 16'h0000;
		o_wdata = 16'h0000;
	end
	task automatic xfer(input fsc_cmd_e cmd, input logic [15:0] addr, input logic [15:0] wdata);
		int n;
		n = 0;
		@(negedge i_clk);
		o_req <= 1'h1;
		o_cmd <= cmd;
		o_addr <= addr;
		o_wdata <= wdata;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_ack !== 1'h1 && n < 9000);
		tmo = tmo | (n >= 9000);
		@(negedge i_clk);
		// released address and data lines must not keep their last value
		o_req <= 1'h0;
		o_addr <= ~addr;
		o_wdata <= ~wdata;
		@(negedge i_clk);
	endtask : xfer
endmodule : fsc_bus_master

/* tb/testbench.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module testbench;
	import fsc_pkg::*;
	typedef struct packed {
		logic        dbg;
		logic        rd;
		logic [15:0] data;
		logic        err;
	} fsc_note_s;
	logic        i_clk = 1'h0;
	logic        i_rst_b = 1'h0;
	logic        i_ce = 1'h1;
	logic        unlock = 1'h0;
	logic        lock = 1'h0;
	logic        cpu_req, dbg_req, cpu_ack, dbg_ack, err, busy, locked, ce_rand = 1'h0;
	fsc_cmd_e    cpu_cmd, dbg_cmd;
	logic [15:0] cpu_addr, cpu_wdata, dbg_addr, dbg_wdata, rdata;
	logic [16:0] rnd = 17'h17A23;
	logic [7:0]  r;
	int          bad_count = 0;
	int          compares = 0;
	fsc_note_s   notes[$];
	fsc_note_s   note;
	always #5 i_clk = ~i_clk;
	fsc_bus_master cpu (.i_clk(i_clk), .i_ack(cpu_ack), .o_req(cpu_req), .o_cmd(cpu_cmd),
		.o_addr(cpu_addr), .o_wdata(cpu_wdata));
	fsc_bus_master dbg (.i_clk(i_clk), .i_ack(dbg_ack), .o_req(dbg_req), .o_cmd(dbg_cmd),
		.o_addr(dbg_addr), .o_wdata(dbg_wdata));
	fsc_flash_segment_control dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_cpu_req(cpu_req), .i_cpu_cmd(cpu_cmd), .i_cpu_addr(cpu_addr),
		.i_cpu_wdata(cpu_wdata), .o_cpu_ack(cpu_ack), .i_dbg_req(dbg_req),
		.i_dbg_cmd(dbg_cmd), .i_dbg_addr(dbg_addr), .i_dbg_wdata(dbg_wdata),
		.o_dbg_ack(dbg_ack), .o_rdata(rdata), .o_err(err), .o_busy(busy),
		.i_sega_unlock(unlock), .i_sega_lock(lock), .o_sega_locked(locked));
	// ------
	// stimulus helpers
	// ------
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : lfsr
	// clock enable stays high in ack cycles so a frozen ack is never seen twice
	always @(negedge i_clk) begin
		rnd <= lfsr(rnd);
		i_ce <= !ce_rand || cpu_ack === 1'h1 || dbg_ack === 1'h1 || rnd[1:0] != 2'h0;
	end
	task automatic complete_run;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic run(input fsc_note_s n, input fsc_cmd_e c, input logic [15:0] a,
		input logic [15:0] w);
		notes.push_back(n);
		if (n.dbg) dbg.xfer(c, a, w);
		else cpu.xfer(c, a, w);
		if (cpu.tmo || dbg.tmo) begin
			bad_count++;
			complete_run;
		end
		`CHK(busy, 1'h0)
	endtask : run
	task automatic op(input logic d, input fsc_cmd_e c, input logic [15:0] a,
		input logic [15:0] w, input logic e);
		run('{d, 1'h0, 16'h0000, e}, c, a, w);
	endtask : op
	task automatic rd(input logic d, input logic [15:0] a, input logic [15:0] x);
		run('{d, 1'h1, x, 1'h0}, CMD_READ, a, 16'h0000);
	endtask : rd
	task automatic tie(input logic [15:0] da, input logic [15:0] dx, input logic [15:0] ca,
		input logic [15:0] cx);
		notes.push_back('{1'h1, 1'h1, dx, 1'h0});
		notes.push_back('{1'h0, 1'h1, cx, 1'h0});
		// both ask at one edge: debug is served first, the cpu waits
		fork
			dbg.xfer(CMD_READ, da, 16'h0000);
			cpu.xfer(CMD_READ, ca, 16'h0000);
		join
		if (cpu.tmo || dbg.tmo) begin
			bad_count++;
			complete_run;
		end
	endtask : tie
	task automatic set_lock(input logic u);
		@(negedge i_clk);
		unlock <= u;
		lock <= !u;
		@(negedge i_clk);
		unlock <= 1'h0;
		lock <= 1'h0;
	endtask : set_lock
	// ------
	// answer monitor
	// ------
	always @(posedge i_clk) begin
		if (cpu_ack === 1'h1 || dbg_ack === 1'h1) begin
			`CHK(notes.size() != 0, 1'h1)
			if (notes.size() != 0) begin
				note = notes.pop_front();
				`CHK(dbg_ack, note.dbg)
				`CHK(err, note.err)
				`CHK(busy, 1'h1)
				if (note.rd) `CHK(rdata, note.data)
			end
		end
	end
	initial begin
		repeat (4) @(negedge i_clk);
		i_rst_b = 1'h1;
		`CHK(locked, 1'h1)
		set_lock(1'h1);
		`CHK(locked, 1'h0)
		op(1'h1, CMD_ERASE_ALL, 16'hF800, 16'h0000, 1'h0);
		rd(1'h0, 16'h10C0, 16'hFFFF);
		rd(1'h0, 16'hFFFE, 16'hFFFF);
		op(1'h0, CMD_PROG_BYTE, 16'h10FE, 16'h005A, 1'h0);
		op(1'h1, CMD_PROG_BYTE, 16'h10FF, 16'h00A5, 1'h0);
		rd(1'h0, 16'h10FE, 16'hA55A);
		rd(1'h1, 16'h10FF, 16'h00A5);
		$display("test calibration done");
		set_lock(1'h0);
		op(1'h0, CMD_PROG_WORD, 16'h10C0, 16'h0000, 1'h1);
		op(1'h0, CMD_ERASE_SEG, 16'h10F3, 16'h0000, 1'h1);
		rd(1'h0, 16'h10C0, 16'hFFFF);
		rd(1'h1, 16'h10FE, 16'hA55A);
		op(1'h0, CMD_READ, 16'h0200, 16'h0000, 1'h1);
		$display("test locked done");
		r = rnd[7:0];
		op(1'h1, CMD_PROG_WORD, 16'hF9FE, 16'h1234, 1'h0);
		op(1'h0, CMD_PROG_BYTE, 16'hFA00, {8'h00, r}, 1'h0);
		rd(1'h0, 16'hF9FE, 16'h1234);
		op(1'h0, CMD_ERASE_SEG, 16'hF801, 16'h0000, 1'h0);
		rd(1'h0, 16'hF9FE, 16'hFFFF);
		rd(1'h0, 16'hFA00, {8'hFF, r});
		$display("test main segment done");
		op(1'h0, CMD_PROG_BYTE, 16'h107F, 16'h0000, 1'h0);
		op(1'h0, CMD_PROG_BYTE, 16'h1080, 16'h0000, 1'h0);
		op(1'h1, CMD_ERASE_SEG, 16'h10A5, 16'h0000, 1'h0);
		rd(1'h0, 16'h107E, 16'h00FF);
		rd(1'h0, 16'h1080, 16'hFFFF);
		$display("test info segment done");
		ce_rand = 1'h1;
		op(1'h1, CMD_ERASE_MASS, 16'hF800, 16'h0000, 1'h0);
		ce_rand = 1'h0;
		rd(1'h0, 16'hFA00, 16'hFFFF);
		rd(1'h0, 16'h107E, 16'h00FF);
		op(1'h1, CMD_ERASE_ALL, 16'hF800, 16'h0000, 1'h0);
		rd(1'h0, 16'h107E, 16'hFFFF);
		rd(1'h0, 16'h10FE, 16'hA55A);
		tie(16'h10FE, 16'hA55A, 16'hF9FE, 16'hFFFF);
		$display("test bulk erase done");
		set_lock(1'h1);
		i_rst_b = 1'h0;
		repeat (4) @(negedge i_clk);
		i_rst_b = 1'h1;
		`CHK(locked, 1'h1)
		$display("test second reset done");
		`CHK(notes.size() == 0, 1'h1)
		complete_run;
	end
endmodule : testbench
